// ---- hw/debug_trace_pkg.sv ----
// Constants for the debug trace and serial port block.
// Assumes a single 100 MHz core clock domain.
package debug_trace_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam logic [3:0] STATUS_IDLE = 4'h0;
    localparam logic [3:0] STATUS_START_C = 4'hc;
    localparam logic [3:0] STATUS_START_D = 4'hd;
    localparam logic [3:0] STATUS_START_F = 4'hf;
    localparam logic [3:0] STATUS_ALL_ONES = 4'hf;
    localparam logic [7:0] FRAME_BITS = 8'h08;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage : debug_trace_pkg

// ---- hw/debug_trace_serial_port.sv ----
// Debug port: serial command shifter plus real-time trace outputs.
// Assumes core status and trace data come from logic on clk; the
// serial clock and serial input come from pins on another clock.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01 - Serial input bit is taken only after serial clock is seen high.
// RULE_02 - Serial output comes from a register, changed after clock-high detection.
// RULE_03 - Trace clock is delayed core clock, rising mid-way through valid trace data; here it toggles every core cycle, running at half the core rate.
// RULE_04 - Disable bit freezes trace clock, status and data; triggers still work.
// RULE_05 - Clearing the disable bit resumes normal trace output toggling.
// RULE_06 - Probe must realign to trace streams after toggling resumes.
// RULE_07 - Trace clock stays idle until first status 0xc, 0xd or 0xf.
// RULE_08 - All-ones indicator is the AND of the four status outputs.
// RULE_09 - Status output updates on core clock, independent of bus transfers.
// RULE_10 - Trace data output shows captured data and breakpoint status.
// RULE_11 - Probe may time sampling from system clock out or trace clock.
// RULE_12 - Serial clock passes a two-stage synchroniser before level detection.
module debug_trace_serial_port
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic serial_debug_clock,
    input wire logic serial_debug_in,
    output logic serial_debug_out,
    input wire logic [7:0] serial_tx_word,
    input wire logic serial_tx_valid,
    output logic serial_tx_ready,
    output logic [7:0] serial_rx_word,
    output logic serial_rx_valid,
    input wire logic serial_rx_ready,
    input wire logic [3:0] core_status_in,
    input wire logic [3:0] trace_data_in,
    input wire logic trace_clock_disable,
    input wire logic breakpoint_in,
    output logic breakpoint_trigger,
    output logic [3:0] core_status,
    output logic [3:0] trace_data,
    output logic trace_clock,
    output logic status_all_ones
);
    import debug_trace_pkg::*;

    // All block state in one packed record
    typedef struct packed {
        // Pin synchronisers and serial clock level history
        logic [1:0] sclk_sync;
        logic [1:0] sdi_sync;
        logic sclk_seen;
        // Serial shifters and frame bit counter
        logic [7:0] rx_shift;
        logic [7:0] tx_shift;
        logic [7:0] bit_cnt;
        // Two-entry receive buffer, serial output bit and transmit ready
        logic [1:0][7:0] buf_word;
        logic [1:0] buf_count;
        logic buf_wr;
        logic buf_rd;
        logic sdo;
        logic tx_ready;
        // Registered copies of the buffer head for the outputs
        logic [7:0] rx_word;
        logic rx_valid;
        // Trace start flag and trace outputs
        logic started;
        logic [3:0] status;
        logic [3:0] data;
        logic all_ones;
        logic tclk;
        logic trig;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic rise;
    logic push;
    logic pop;

    // Detect high level of the synchronised serial clock
    assign rise = state_reg.sclk_sync[1] && !state_reg.sclk_seen; // RULE_01
    assign push = rise && (state_reg.bit_cnt == FRAME_BITS - 8'h01) &&
                  (state_reg.buf_count != BUF_DEPTH);
    assign pop = serial_rx_valid && serial_rx_ready;

    // Next-state logic
    always_comb
    begin
        state_next = state_reg;
        state_next.sclk_sync = {state_reg.sclk_sync[0], serial_debug_clock}; // RULE_12
        state_next.sdi_sync = {state_reg.sdi_sync[0], serial_debug_in};
        state_next.sclk_seen = state_reg.sclk_sync[1];
        // Ready only between frames; a taken word drops it at once
        state_next.tx_ready = (state_reg.bit_cnt == 8'h00) && !serial_tx_valid;
        if (serial_tx_valid && state_reg.tx_ready)
        begin
            state_next.tx_shift = serial_tx_word;
            state_next.tx_ready = 1'b0;
        end
        if (rise)
        begin
            // Shift one bit in, one bit out on each clock-high
            state_next.rx_shift = {state_reg.rx_shift[6:0], state_reg.sdi_sync[1]}; // RULE_01
            state_next.sdo = state_reg.tx_shift[7]; // RULE_02
            state_next.tx_shift = {state_reg.tx_shift[6:0], 1'b0};
            if (state_reg.bit_cnt == FRAME_BITS - 8'h01)
                state_next.bit_cnt = 8'h00;
            else
                state_next.bit_cnt = state_reg.bit_cnt + 8'h01;
        end
        // Two-entry receive buffer
        if (push)
        begin
            state_next.buf_word[state_reg.buf_wr] = {state_reg.rx_shift[6:0],
                                                     state_reg.sdi_sync[1]};
            state_next.buf_wr = !state_reg.buf_wr;
        end
        if (pop)
            state_next.buf_rd = !state_reg.buf_rd;
        state_next.buf_count = state_reg.buf_count + {1'b0, push} - {1'b0, pop};
        // Head word and valid taken from the next state, so the
        // flopped outputs show the buffer in the same cycle
        state_next.rx_valid = (state_next.buf_count != 2'h0);
        state_next.rx_word = state_next.buf_word[state_next.buf_rd];
        // Trace start and freeze
        if (!state_reg.started && (core_status_in == STATUS_START_C ||
            core_status_in == STATUS_START_D || core_status_in == STATUS_START_F))
            state_next.started = 1'b1; // RULE_07
        // Breakpoint triggers pass through even while the trace is frozen
        state_next.trig = breakpoint_in; // RULE_04
        // Freeze holds trace clock, status, data and all-ones; clearing it resumes toggling
        if (!trace_clock_disable) // RULE_05
        begin
            // Trace clock runs at half the core rate once started
            state_next.tclk = state_reg.started ? !state_reg.tclk : 1'b0; // RULE_03
            // New trace word every cycle before start, then only as the trace clock falls, so that its
            // rising edge lands in the middle of a two-cycle valid window
            if (!state_reg.started || state_reg.tclk) // RULE_03
            begin
                state_next.status = core_status_in; // RULE_09
                state_next.data = trace_data_in; // RULE_10
                state_next.all_ones = (core_status_in == STATUS_ALL_ONES); // RULE_08
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign serial_debug_out = state_reg.sdo;
    assign serial_tx_ready = state_reg.tx_ready;
    assign serial_rx_word = state_reg.rx_word;
    assign serial_rx_valid = state_reg.rx_valid;
    assign core_status = state_reg.status;
    assign trace_data = state_reg.data;
    assign trace_clock = state_reg.tclk;
    assign status_all_ones = state_reg.all_ones;
    assign breakpoint_trigger = state_reg.trig;

    // Checks, all on the core clock
    // Indicator always matches the AND of the status bits
    a_all_ones_and: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
        status_all_ones == (&core_status))
        else $error("all-ones mismatch");
    // Nothing on the trace moves in the cycle after a freeze
    a_freeze_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        $past(trace_clock_disable) |-> $stable(core_status) && $stable(trace_clock)
        && $stable(trace_data) && $stable(status_all_ones))
        else $error("trace moved while disabled");
    // Trace clock stays low until a start code is seen
    a_idle_start: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        !state_reg.started |=> !trace_clock)
        else $error("trace clock early");
    // Once started the start flag stays set until reset
    a_started_hold: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        state_reg.started |=> state_reg.started)
        else $error("start flag lost");
    // Status takes a new word as the trace clock falls
    a_status_follow: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        !trace_clock_disable && (trace_clock || !state_reg.started)
        |=> core_status == $past(core_status_in))
        else $error("status not updated");
    // Trace data takes a new word as the trace clock falls
    a_data_follow: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        !trace_clock_disable && (trace_clock || !state_reg.started)
        |=> trace_data == $past(trace_data_in))
        else $error("data not updated");
    // Trace word stands still across each rising trace clock edge
    a_mid_window: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
        $rose(trace_clock) |-> $stable(core_status) && $stable(trace_data))
        else $error("trace word moved at clock rise");
    // Toggling resumes once the freeze is lifted
    a_resume_toggle: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
        !trace_clock_disable && state_reg.started ##1 !trace_clock_disable
        |=> trace_clock != $past(trace_clock))
        else $error("no toggle");
    // Serial output changes only on a detected clock-high
    a_sdo_on_rise: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        !rise |=> $stable(serial_debug_out))
        else $error("sdo moved");
    // Receive shifter changes only on a detected clock-high
    a_rx_on_rise: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        !rise |=> $stable(state_reg.rx_shift))
        else $error("rx moved");
    // Trigger follows its input one cycle later
    a_trig_live: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        breakpoint_in |=> breakpoint_trigger)
        else $error("trigger lost");
    // Trigger still works while the trace is frozen
    a_trig_frozen: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        trace_clock_disable && !breakpoint_in |=> !breakpoint_trigger)
        else $error("trigger stuck while frozen");
    // Clock-high detection only after two synchroniser stages
    a_sync_delay: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
        rise |-> $past(serial_debug_clock, 2))
        else $error("sync bypass");
    // Receive buffer never holds more than its depth
    a_buf_bound: assert property (@(posedge clk) disable iff (!rstn)
        state_reg.buf_count <= BUF_DEPTH)
        else $error("buffer overfilled");
endmodule : debug_trace_serial_port

`default_nettype wire

// ---- test/debug_probe_model.sv ----
// Probe model: drives the serial clock and input, samples the output.
// Assumes the design samples both pins on its own clock.
`timescale 1ns/1ps
`default_nettype none
module debug_probe_model
(
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    logic [7:0] seen;
    // Pins idle low until a frame
    initial
    begin
        sck = 1'b0;
        sdi = 1'b0;
    end
    // One frame, MSB first, 125 ns a bit; clock stands still after it
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            sdi = b[i];
            #12 sck = 1'b1;
            #62.5 sck = 1'b0;
            seen[i] = sdo;
            sdi = ~b[i]; // Hold over, old bit gone
            #50.5;
        end
    endtask : send
endmodule : debug_probe_model
`default_nettype wire

// ---- test/debug_trace_serial_port_test.sv ----
// Bench: random trace traffic with freeze, serial frames via probe.
// Assumes the probe model and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module debug_trace_serial_port_test;
    import debug_trace_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, sck, sdi, sdo, txv = 1'b0, txr, rxv, rxr = 1'b0;
    logic dis = 1'b0, bi = 1'b0, bo, tck, all1, pdis, pb, et;
    logic [7:0] txw = 8'h00, rxw, tx;
    logic [7:0] w [3];
    logic [3:0] si = 4'h0, di = 4'h0, st, td, ps, pd, es, ed;
    logic [3:0] q [3] = '{STATUS_START_C, STATUS_START_D, STATUS_START_F};
    int errors = 0, num_checks = 0;
    // Core clock
    always #5 clk = ~clk;
    debug_probe_model debug_probe_model_inst (.sck(sck), .sdi(sdi), .sdo(sdo));
    debug_trace_serial_port debug_trace_serial_port_inst (.clk(clk), .rstn(rstn),
        .serial_debug_clock(sck), .serial_debug_in(sdi), .serial_debug_out(sdo),
        .serial_tx_word(txw), .serial_tx_valid(txv), .serial_tx_ready(txr),
        .serial_rx_word(rxw), .serial_rx_valid(rxv), .serial_rx_ready(rxr),
        .core_status_in(si), .trace_data_in(di), .trace_clock_disable(dis),
        .breakpoint_in(bi), .breakpoint_trigger(bo), .core_status(st),
        .trace_data(td), .trace_clock(tck), .status_all_ones(all1));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // Watchdog
    initial
    begin
        #100us;
        errors++;
        finish_test();
    end
    // One pass per start code, each from reset
    initial
    begin
        void'($urandom(32'hf83596c7));
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            rstn <= 1'b0;
            si <= 4'h0;
            repeat (8) @(posedge clk);
            rstn <= 1'b1;
            repeat (12) @(posedge clk);
            chk("idle clock", 8'h00, {7'h00, tck});
            si <= q[k];
            repeat (3) @(posedge clk);
            #1 et = tck;
            {ps, pd, pdis, pb, es, ed} = {q[k], di, 1'b0, bi, q[k], di};
            for (int i = 0; i < 24; i++)
            begin
                @(posedge clk);
                si <= $urandom;
                di <= $urandom;
                bi <= $urandom;
                dis <= (i > 7 && i < 16);
                if (!pdis && et)
                    {es, ed} = {ps, pd};
                if (!pdis)
                    et = ~et;
                #1;
                chk("status", es, st);
                chk("data", ed, td);
                chk("tclk", et, tck);
                chk("all1", &es, all1);
                chk("trigger", pb, bo);
                {ps, pd, pdis, pb} = {si, di, dis, bi};
            end
            tx = $urandom;
            txw <= tx;
            txv <= 1'b1;
            do @(posedge clk); while (txr !== 1'b1);
            txv <= 1'b0;
            // Third frame meets a full buffer and is dropped
            for (int j = 0; j < 3; j++)
            begin
                w[j] = $urandom;
                debug_probe_model_inst.send(w[j]);
                if (j == 0)
                    chk("sdo", tx, debug_probe_model_inst.seen);
            end
            for (int j = 0; j < 2; j++)
            begin
                @(posedge clk);
                chk("rx word", w[j], rxw);
                rxr <= 1'b1;
                @(posedge clk);
                rxr <= 1'b0;
            end
            @(posedge clk);
            #1 chk("rx empty", 8'h00, {7'h00, rxv});
        end
        finish_test();
    end
endmodule : debug_trace_serial_port_test
`default_nettype wire
